// [rtl/mdios_slave.sv]
`timescale 1ns/1ps
`include "mdios_cfg.svh"
module mdios_slave
  import mdios_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] port_base_address_pins,
  output logic [2:0] reg_port_q,
  output logic [4:0] reg_addr_q,
  output logic [15:0] wr_data_q,
  output logic wr_stb_q,
  output logic rd_req_q,
  input wire logic [15:0] rd_data
);

////////////////////////////////////////////////////////////////////////////
// pin synchronisers and strap capture

  logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
  logic dat_s1_q, dat_s2_q;
  logic [4:0] base_s1_q, base_q;

  always_ff @(posedge core_clk) begin
    mdc_s1_q <= mdc;
    mdc_s2_q <= mdc_s1_q;
    mdc_s3_q <= mdc_s2_q;
    dat_s1_q <= mdio_i;
    dat_s2_q <= dat_s1_q;
    base_s1_q <= port_base_address_pins;
    base_q <= base_s1_q;
  end

  // mdc is slow (4+ clk per bit), so data synced alongside stays aligned
  wire mdc_rise = mdc_s2_q && !mdc_s3_q;
  wire bit_in = dat_s2_q;

////////////////////////////////////////////////////////////////////////////
// frame decoder

  mdios_state_t st_q, st_d;
  logic [5:0] ones_q;
  logic [4:0] cnt_q;
  logic first_q;
  logic is_rd_q;
  logic [9:0] hdr_q;
  logic [15:0] sh_q;
  logic drv_q, drv_val_q;
  logic match_q;

  // port judged at its last bit, before register bits shift in
  wire [4:0] rx_phy = {hdr_q[3:0], bit_in};
  wire [4:0] port_off = 5'(rx_phy - base_q);
  wire port_hit = port_off < 5'(`MDIOS_NUM_PORTS);
  wire pre_ok = ones_q >= `MDIOS_PRE_BITS;
  wire [1:0] two = {first_q, bit_in};

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      MDIOS_PRE: if (!bit_in && pre_ok) st_d = MDIOS_ST;
      MDIOS_ST: st_d = (two == `MDIOS_START_PAT) ? MDIOS_OP : MDIOS_PRE;
      MDIOS_OP: if (cnt_q == 5'd1) begin
        st_d = (two == `MDIOS_OP_READ || two == `MDIOS_OP_WRITE) ?
               MDIOS_HDR : MDIOS_PRE;
      end
      MDIOS_HDR: if (cnt_q == 5'd9) st_d = MDIOS_TA;
      MDIOS_TA: if (cnt_q == 5'd1) st_d = MDIOS_DATA;
      MDIOS_DATA: if (cnt_q == 5'd15) st_d = MDIOS_CLOSE;
      MDIOS_CLOSE: st_d = MDIOS_PRE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= MDIOS_PRE;
      ones_q <= 6'h00;
      cnt_q <= 5'h00;
      first_q <= 1'b0;
      is_rd_q <= 1'b0;
      hdr_q <= 10'h000;
      sh_q <= 16'h0000;
      match_q <= 1'b0;
      drv_q <= 1'b0;
      drv_val_q <= 1'b1;
      reg_port_q <= 3'h0;
      reg_addr_q <= 5'h00;
      wr_data_q <= 16'h0000;
      wr_stb_q <= 1'b0;
      rd_req_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      rd_req_q <= 1'b0;
      if (mdc_rise) begin
        st_q <= st_d;
        first_q <= bit_in;
        // preamble count of consecutive ones, saturating
        if (!bit_in) ones_q <= 6'h00;
        else if (!pre_ok) ones_q <= 6'(ones_q + 6'h01);
        cnt_q <= (st_d != st_q) ? 5'h00 : 5'(cnt_q + 5'h01);
        if (st_q == MDIOS_OP && cnt_q == 5'd1) begin
          is_rd_q <= (two == `MDIOS_OP_READ);
        end
        if (st_q == MDIOS_HDR) begin
          hdr_q <= {hdr_q[8:0], bit_in};
          if (cnt_q == 5'd4) begin
            match_q <= port_hit;
            reg_port_q <= port_off[2:0];
          end
        end
        if (st_q == MDIOS_HDR && cnt_q == 5'd9) begin
          reg_addr_q <= {hdr_q[3:0], bit_in};
          rd_req_q <= is_rd_q && match_q;
          drv_q <= 1'b0; // first ta bit released
        end
        // rd_data taken at first ta rise: user side has one mdc bit
        if (st_q == MDIOS_TA && cnt_q == 5'd0 && is_rd_q && match_q) begin
          drv_q <= 1'b1;
          drv_val_q <= 1'b0;
          sh_q <= rd_data;
        end
        if (st_q == MDIOS_TA && cnt_q == 5'd1 && drv_q) begin
          drv_val_q <= sh_q[15];
          sh_q <= {sh_q[14:0], 1'b0};
        end
        if (st_q == MDIOS_DATA) begin
          if (drv_q) begin
            drv_val_q <= sh_q[15];
            sh_q <= {sh_q[14:0], 1'b0};
          end else begin
            sh_q <= {sh_q[14:0], bit_in};
          end
          if (cnt_q == 5'd15) drv_q <= 1'b0;
        end
        if (st_q == MDIOS_CLOSE) begin
          // 65th pulse commits the captured write
          if (!is_rd_q && match_q) begin
            wr_data_q <= sh_q;
            wr_stb_q <= 1'b1;
          end
          match_q <= 1'b0;
          drv_val_q <= 1'b1;
        end
      end
    end
  end

  assign mdio_o = drv_val_q;
  assign mdio_oe = drv_q;

////////////////////////////////////////////////////////////////////////////
// checks

  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic [4:0] oe_rises_q;
  always_ff @(posedge core_clk) begin
    if (rst) oe_rises_q <= 5'h00;
    else if (!drv_q) oe_rises_q <= 5'h00;
    else if (mdc_rise) oe_rises_q <= 5'(oe_rises_q + 5'h01);
  end

  chk_drive_len_max: assert property (
    oe_rises_q <=
    `MDIOS_RD_DRIVE_BITS)
    else $error("read drive exceeded seventeen bits");

  chk_drive_len_exact: assert property (
    $fell(drv_q) |->
    $past(oe_rises_q) == 5'd16)
    else $error("read drive not seventeen bits");

  chk_ta_zero: assert property (
    $rose(drv_q) |->
    !mdio_o && st_q == MDIOS_TA)
    else $error("second turnaround bit not zero");

  chk_oe_needs_hit: assert property (
    drv_q |->
    match_q && is_rd_q)
    else $error("drive without address match");

  chk_oe_on_edge: assert property (
    $changed(mdio_o) |->
    $past(mdc_rise))
    else $error("read data changed off mdc rise");

  chk_wr_commit: assert property (
    wr_stb_q |->
    $past(st_q) == MDIOS_CLOSE && !is_rd_q)
    else $error("write committed outside closing pulse");

  chk_short_pre: assert property (
    (mdc_rise && st_q == MDIOS_PRE && !bit_in && !pre_ok) |=>
    st_q == MDIOS_PRE)
    else $error("frame accepted after short preamble");

  chk_idle_release: assert property (
    st_q == MDIOS_PRE |->
    !drv_q)
    else $error("line driven while idle");

  chk_idle_high: assert property (
    st_q == MDIOS_PRE |->
    mdio_o)
    else $error("idle output value not one");

  chk_wr_single: assert property (
    wr_stb_q |=>
    !wr_stb_q)
    else $error("write strobe longer than one cycle");

  chk_wr_hit: assert property (
    wr_stb_q |->
    $past(match_q))
    else $error("write committed without address match");

  chk_rdreq_single: assert property (
    rd_req_q |=>
    !rd_req_q)
    else $error("read request longer than one cycle");

  chk_rdreq_hit: assert property (
    rd_req_q |->
    match_q && is_rd_q)
    else $error("read request without matched read");

  chk_rdreq_place: assert property (
    rd_req_q |->
    st_q == MDIOS_TA)
    else $error("read request not at end of header");

  chk_oe_window: assert property (
    drv_q |->
    st_q == MDIOS_TA || st_q == MDIOS_DATA)
    else $error("line driven outside turnaround or data");

  chk_oe_rise_ta: assert property (
    $rose(drv_q) |->
    $past(st_q) == MDIOS_TA)
    else $error("drive began outside turnaround");

  chk_oe_fall_close: assert property (
    $fell(drv_q) |->
    st_q == MDIOS_CLOSE)
    else $error("drive ended off the last data bit");

  chk_data_len: assert property (
    st_q == MDIOS_DATA |->
    cnt_q <= 5'd15)
    else $error("data field longer than sixteen bits");

  chk_hdr_len: assert property (
    st_q == MDIOS_HDR |->
    cnt_q <= 5'd9)
    else $error("address fields longer than ten bits");

  chk_ta_len: assert property (
    st_q == MDIOS_TA |->
    cnt_q <= 5'd1)
    else $error("turnaround longer than two bits");

  chk_op_len: assert property (
    st_q == MDIOS_OP |->
    cnt_q <= 5'd1)
    else $error("opcode longer than two bits");

  chk_start_entry: assert property (
    $changed(st_q) && st_q == MDIOS_ST |->
    $past(st_q) == MDIOS_PRE)
    else $error("start hunt not entered from preamble");

  chk_op_after_start: assert property (
    $changed(st_q) && st_q == MDIOS_OP |->
    $past(st_q) == MDIOS_ST && $past(two) == `MDIOS_START_PAT)
    else $error("opcode entered without start pattern");

  chk_hdr_opcode: assert property (
    $changed(st_q) && st_q == MDIOS_HDR |->
    $past(two) == `MDIOS_OP_READ || $past(two) == `MDIOS_OP_WRITE)
    else $error("address fields entered with bad opcode");

  chk_state_on_mdc: assert property (
    $changed(st_q) |->
    $past(mdc_rise))
    else $error("state moved off an mdc rise");

endmodule : mdios_slave

// [rtl/mdios_cfg.svh]
`ifndef MDIOS_CFG_SVH
`define MDIOS_CFG_SVH
`define MDIOS_PRE_BITS 6'd32
`define MDIOS_START_PAT 2'b01
`define MDIOS_OP_READ 2'b10
`define MDIOS_OP_WRITE 2'b01
`define MDIOS_TA_WRITE 2'b10
`define MDIOS_NUM_PORTS 4'd8
`define MDIOS_ADDR_BITS 4'd5
`define MDIOS_DATA_BITS 5'd16
`define MDIOS_RD_DRIVE_BITS 5'd17
`define MDIOS_MDC_MAX_MHZ 25
`define MDIOS_CLK_MHZ 100
// least clk cycles per mdc bit at top rate
`define MDIOS_MIN_BIT_CYC ((`MDIOS_CLK_MHZ + `MDIOS_MDC_MAX_MHZ - 1) / `MDIOS_MDC_MAX_MHZ)
`endif

// [rtl/mdios_pkg.sv]
package mdios_pkg;
  typedef enum logic [2:0] {
    MDIOS_PRE, MDIOS_ST, MDIOS_OP, MDIOS_HDR, MDIOS_TA, MDIOS_DATA,
    MDIOS_CLOSE
  } mdios_state_t;
endpackage : mdios_pkg

// [dv/mdios_mgmt_model.sv]
`timescale 1ns/1ps
module mdios_mgmt_model (
  output logic mdc,
  output logic drv_o,
  output logic drv_oe,
  input wire logic line
);
  logic [15:0] rd_q;
  logic [1:0] ta_q;
  logic s;
  initial begin
    mdc = 1'b0;
    drv_o = 1'b1;
    drv_oe = 1'b0;
  end
  ////////////////////////////////////////
  // one bit per 80 ns period, set while mdc low
  task automatic bit_t(input logic oe, input logic v);
    drv_oe = oe;
    drv_o = v;
    #40 mdc = 1'b1;
    s = line;
    #40 mdc = 1'b0;
  endtask : bit_t
  task automatic frame(input int pre, input logic [1:0] op,
      input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
    logic [13:0] hdr;
    logic wr;
    hdr = {2'b01, op, phy, ra};
    wr = (op != 2'b10);
    for (int i = 0; i < pre; i++) bit_t(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) bit_t(1'b1, hdr[i]);
    bit_t(wr, 1'b1);
    ta_q[1] = s;
    bit_t(wr, 1'b0);
    ta_q[0] = s;
    for (int i = 15; i >= 0; i--) begin
      bit_t(wr, d[i]);
      rd_q[i] = s;
    end
    bit_t(1'b0, 1'b1);
    // mdc stands still between frames
    #160;
  endtask : frame
endmodule : mdios_mgmt_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic core_clk, rst, mdc, mdio_o, mdio_oe, drv_o, drv_oe, line;
  logic wr_stb_q, rd_req_q, hit;
  logic [4:0] base, reg_addr_q, ra;
  logic [2:0] reg_port_q;
  logic [1:0] op;
  logic [15:0] wr_data_q, rd_data, d;
  logic [15:0] mem [8][32];
  logic [15:0] exp_m [8][32];
  int err_total, checks, oe_cnt, wr_cnt, pre, off, w0;
  // pull-up holds a released line high
  assign line = (mdio_oe === 1'b1) ? mdio_o : (drv_oe ? drv_o : 1'b1);
  mdios_slave uut (.core_clk(core_clk), .rst(rst), .mdc(mdc),
    .mdio_i(line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .port_base_address_pins(base), .reg_port_q(reg_port_q),
    .reg_addr_q(reg_addr_q), .wr_data_q(wr_data_q), .wr_stb_q(wr_stb_q),
    .rd_req_q(rd_req_q), .rd_data(rd_data));
  mdios_mgmt_model m (.mdc(mdc), .drv_o(drv_o), .drv_oe(drv_oe),
    .line(line));
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // register file stand-in on the user side
  always @(posedge core_clk) begin
    #1;
    if (wr_stb_q === 1'b1) begin
      mem[reg_port_q][reg_addr_q] = wr_data_q;
      wr_cnt++;
    end
    if (rd_req_q === 1'b1) rd_data = mem[reg_port_q][reg_addr_q];
  end
  // contention inflates the count so it cannot pass
  always @(posedge mdc) if (mdio_oe === 1'b1) oe_cnt += drv_oe ? 100 : 1;
  task automatic cmp(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp
  task automatic wrap_up();
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #1ms;
    err_total++;
    wrap_up();
  end
  ////////////////////////////////////////
  initial begin
    err_total = 0;
    checks = 0;
    oe_cnt = 0;
    wr_cnt = 0;
    rst = 1'b1;
    rd_data = 16'h0000;
    void'($urandom(54307));
    base = 5'($urandom);
    for (int p = 0; p < 8; p++) for (int r = 0; r < 32; r++) begin
      mem[p][r] = 16'($urandom);
      exp_m[p][r] = mem[p][r];
    end
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    // short preamble first: trailing ones of a frame count as preamble
    for (int i = 0; i < 24; i++) begin
      pre = (i == 0) ? 31 : $urandom_range(32, 33);
      off = (i < 3) ? 7 : $urandom_range(0, 9);
      op = (i < 2) ? 2'b01 : (i == 2) ? 2'b10 : 2'($urandom);
      ra = (i < 3) ? 5'h1f : 5'($urandom);
      d = 16'($urandom);
      hit = pre >= 32 && off < 8 && (op == 2'b01 || op == 2'b10);
      w0 = wr_cnt;
      oe_cnt = 0;
      m.frame(pre, op, 5'(base + off), ra, d);
      #400;
      if (hit && op == 2'b01) exp_m[off][ra] = d;
      cmp(16'(wr_cnt - w0), {15'h0, hit && op == 2'b01});
      cmp(16'(oe_cnt), (hit && op == 2'b10) ? 16'h0011 : 16'h0000);
      if (hit && op == 2'b10) begin
        cmp({14'h0, m.ta_q}, 16'h0002);
        cmp(m.rd_q, exp_m[off][ra]);
      end
    end
    wrap_up();
  end
endmodule : tb_top
